// file: inc/cpu_entry_defs.vh
// Constants and operation summary for the CPU reset and interrupt entry unit
// Operation
// RULE_01: Reset pin must stay low at least 10 system clocks with oscillator stable.
// RULE_02: Reset loads program counter 8000H and system stack pointer 100H.
// RULE_03: Reset sets system mode 1, mask 111, maximum mode 0, bank 000.
// RULE_04: Reset leaves every other CPU register at its previous value.
// RULE_05: Reset makes ports inputs, watchdog pin 0, clock out 1, latch strobe 0.
// RULE_06: Twenty-three sources: three CPU traps, six pins, fourteen peripherals.
// RULE_07: Fixed vector per source; maskable six levels; non-maskable level 7.
// RULE_08: Controller presents only the highest pending priority, 7 ranking highest.
// RULE_09: Accept only when presented priority is strictly above the mask level; the code also accepts non-maskable level 7 at mask 7.
// RULE_10: Set-mask instruction loads n; block-maskable instruction loads 7.
// RULE_11: New mask level applies to acceptance right after the instruction.
// RULE_12: CPU reads vector; controller gives smallest same-level vector and clears it.
// RULE_13: After vector fetch push program counter, then status register.
// RULE_14: Mask becomes accepted level plus one, saturating at 7.
// RULE_15: Set system mode, then branch to 8000H plus vector.
// RULE_16: Entry takes 15/17 states on 16-bit stack, 19/23 on 8-bit.
// RULE_17: Return instruction pops program counter and status, restoring mask.
// RULE_18: Higher request during entry is accepted before handler starts, nesting.
// RULE_19: Request at level of the interrupt in service is not accepted; the code still accepts non-maskable level 7 while level 7 is in service.
// RULE_20: Addresses 008000H to 0081FFH form the handler entry area.
// RULE_21: Vectors 10H apart; start code is vector divided by 16, from 08H.
// RULE_22: Accepted interrupt may instead run a one-item micro DMA move.
// RULE_23: Maskable source programmed at 0 or 7 never reaches the CPU.
// RULE_24: Micro DMA only when start code matches one of four channel vectors.
// RULE_25: Acceptance only at instruction boundaries or during entry.
`ifndef CPU_ENTRY_DEFS_VH
`define CPU_ENTRY_DEFS_VH
`define RESET_PC 24'h008000
`define RESET_XSP 32'h00000100
`define VECTOR_BASE 24'h008000
`define ENTRY_AREA_LAST 24'h0081ff
`define RESET_MASK 3'h7
`define RESET_BANK 3'h0
`define LEVEL_MAX 3'h7
`define MIN_START_CODE 8'h08
`define SR_MAX_BIT 7
`define SR_SYSTEM_MODE_FLAG_BIT 15
`define SR_MASK_LSB 12
`define SR_BANK_LSB 8
`define STATES_MIN16 5'd15
`define STATES_MAX16 5'd17
`define STATES_MIN8 5'd19
`define STATES_MAX8 5'd23
`define RESET_HOLD_CYCLES 4'd10
`define DMA_CHANNELS 4
`endif

// file: rtl/start_code_match.v
// Compares a start code against the micro DMA channel start vectors
`timescale 1ns/1ps
`default_nettype none
`include "cpu_entry_defs.vh"
module start_code_match #(
	parameter CHANNELS = `DMA_CHANNELS
) (
	// Code under test and channel start vectors
	input wire [7:0] startCode,
	input wire [8*CHANNELS-1:0] channelVectors,
	// Per-channel hit
	output wire [CHANNELS-1:0] hit
);
	genvar i;
	generate
		for (i = 0; i < CHANNELS; i = i + 1) begin : g_ch
			// Codes below 08H never start a transfer
			assign hit[i] = (startCode >= `MIN_START_CODE) &&
				(channelVectors[8*i+7:8*i] == startCode); // RULE_24 RULE_21
		end
	endgenerate
endmodule
`default_nettype wire

// file: rtl/cpu_reset_and_interrupt_entry.v
// CPU reset state and interrupt acceptance and entry sequencer
`timescale 1ns/1ps
`default_nettype none
`include "cpu_entry_defs.vh"
module cpu_reset_and_interrupt_entry (
	// Clock and reset
	input wire clk,
	input wire rst_b,
	// Request from the interrupt controller
	input wire [2:0] requestLevel,
	input wire [8:0] requestVector,
	input wire requestMaskable,
	// Micro DMA start vectors, one byte per channel
	input wire [8*`DMA_CHANNELS-1:0] dmaStartVectors,
	// Instruction flow
	input wire instructionBoundary,
	input wire setMaskInstruction,
	input wire [2:0] setMaskOperand,
	input wire blockMaskableInstruction,
	input wire returnFromHandlerInstruction,
	input wire [23:0] poppedPc,
	input wire [15:0] poppedSr,
	input wire popValid,
	input wire [23:0] currentPc,
	input wire maxMode,
	input wire stackBus8,
	input wire [31:0] stackPointerIn,
	input wire stackPointerLoad,
	// Vector read and push strobes
	output reg vectorRead,
	output reg pushPc,
	output reg pushSr,
	output reg [23:0] pushPcData,
	output reg [15:0] pushSrData,
	// CPU state
	output reg [23:0] programCounter,
	output reg [31:0] systemStackPointer,
	output reg [2:0] interruptMaskLevel,
	output reg systemModeFlag,
	output reg maximumModeFlag,
	output reg [2:0] registerBankPointer,
	output reg branchTaken,
	output reg entryBusy,
	// Micro DMA trigger
	output reg dmaStart,
	output reg [1:0] dmaChannel,
	// Pin states
	output reg portsInput,
	output reg watchdogOutputPin,
	output reg watchdogEnable,
	output reg clockOutput,
	output reg addressLatchStrobe
);
	// ****************************************
	// Declarations
	// ****************************************
	localparam ST_IDLE = 2'd0;
	localparam ST_PUSH = 2'd1;
	localparam ST_WAIT = 2'd2;
	localparam ST_JUMP = 2'd3;
	reg [1:0] state;
	reg [1:0] next_state;
	reg [4:0] stateCount;
	reg [8:0] heldVector;
	reg [2:0] heldLevel;
	reg [2:0] servicedLevel;
	reg resetSync1;
	reg resetSync2;
	wire [`DMA_CHANNELS-1:0] dmaHit;
	wire [7:0] startCode;
	wire effectiveRequest;
	wire acceptWindow;
	wire accept;
	wire [2:0] maskNow;
	wire [4:0] entryStates;
	wire [2:0] raisedMask;
	wire [15:0] srNow;
	wire [23:0] handlerAddr;
	reg [1:0] hitIndex;
	integer k;

	// ****************************************
	// Acceptance
	// ****************************************
	// Mask written this cycle is seen at once
	assign maskNow = setMaskInstruction ? setMaskOperand : // RULE_10 RULE_11
		(blockMaskableInstruction ? `LEVEL_MAX : interruptMaskLevel); // RULE_10
	// Disabled maskable levels are ignored
	assign effectiveRequest = !(requestMaskable &&
		(requestLevel == 3'h0 || requestLevel == `LEVEL_MAX)); // RULE_23 RULE_07
	assign acceptWindow = (state == ST_IDLE) ? instructionBoundary : (state == ST_WAIT); // RULE_25 RULE_18
	// Level 7 nests over level 7; otherwise strictly above mask, and not at the in-service level during entry
	assign accept = acceptWindow && effectiveRequest && !vectorRead &&
		((requestLevel > maskNow) || // RULE_09 RULE_08
		(requestLevel == `LEVEL_MAX && !requestMaskable)) &&
		!(requestMaskable && requestLevel == servicedLevel && state != ST_IDLE); // RULE_19
	assign raisedMask = (heldLevel == `LEVEL_MAX) ? `LEVEL_MAX : heldLevel + 3'h1; // RULE_14
	assign entryStates = stackBus8 ? (maximumModeFlag ? `STATES_MAX8 : `STATES_MIN8) :
		(maximumModeFlag ? `STATES_MAX16 : `STATES_MIN16); // RULE_16
	assign startCode = {3'h0, heldVector[8:4]}; // RULE_21
	// Bit 11 is unused and reads as zero
	assign srNow = {systemModeFlag, interruptMaskLevel, 1'b0, registerBankPointer,
		maximumModeFlag, 7'h00};
	assign handlerAddr = `VECTOR_BASE + {15'h0000, heldVector}; // RULE_15 RULE_20

	start_code_match #(
		.CHANNELS(`DMA_CHANNELS)
	) u_match (
		.startCode(startCode),
		.channelVectors(dmaStartVectors),
		.hit(dmaHit)
	);

	always @* begin
		hitIndex = 2'd0;
		for (k = `DMA_CHANNELS - 1; k >= 0; k = k - 1) begin
			if (dmaHit[k]) begin
				hitIndex = k[1:0];
			end
		end
	end

	// ****************************************
	// Entry sequencer
	// ****************************************
	always @* begin
		next_state = state;
		case (state)
			ST_IDLE: begin
				if (accept) begin
					next_state = ST_PUSH;
				end
			end
			ST_PUSH: begin
				next_state = (|dmaHit) ? ST_IDLE : ST_WAIT; // RULE_22 RULE_24
			end
			ST_WAIT: begin
				if (accept) begin
					next_state = ST_PUSH;
				end else if (stateCount >= entryStates - 5'd2) begin
					next_state = ST_JUMP;
				end
			end
			ST_JUMP: begin
				next_state = ST_IDLE;
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
	end

	// Reset release passes two flops; assertion stays asynchronous
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			resetSync1 <= 1'b0;
			resetSync2 <= 1'b0;
		end else begin
			resetSync1 <= 1'b1;
			resetSync2 <= resetSync1;
		end
	end

	// Reset loads the listed state and also clears every sequencer, held request, strobe and push data register
	always @(posedge clk or negedge resetSync2) begin
		if (!resetSync2) begin
			state <= ST_IDLE;
			stateCount <= 5'd0;
			programCounter <= `RESET_PC; // RULE_02
			systemStackPointer <= `RESET_XSP; // RULE_02
			systemModeFlag <= 1'b1; // RULE_03
			interruptMaskLevel <= `RESET_MASK; // RULE_03
			maximumModeFlag <= 1'b0; // RULE_03
			registerBankPointer <= `RESET_BANK; // RULE_03 RULE_04
			heldVector <= 9'h000;
			heldLevel <= 3'h0;
			servicedLevel <= 3'h0;
			vectorRead <= 1'b0;
			pushPc <= 1'b0;
			pushSr <= 1'b0;
			pushPcData <= 24'h000000;
			pushSrData <= 16'h0000;
			branchTaken <= 1'b0;
			entryBusy <= 1'b0;
			dmaStart <= 1'b0;
			dmaChannel <= 2'd0;
			portsInput <= 1'b1; // RULE_05
			watchdogOutputPin <= 1'b0; // RULE_05
			watchdogEnable <= 1'b1; // RULE_05
			clockOutput <= 1'b1; // RULE_05
			addressLatchStrobe <= 1'b0; // RULE_05
		end else begin
			state <= next_state;
			vectorRead <= 1'b0;
			pushPc <= 1'b0;
			pushSr <= 1'b0;
			branchTaken <= 1'b0;
			dmaStart <= 1'b0;
			entryBusy <= (next_state != ST_IDLE);
			maximumModeFlag <= maxMode;
			clockOutput <= ~clockOutput;
			if (stackPointerLoad) begin
				systemStackPointer <= stackPointerIn;
			end
			if (setMaskInstruction || blockMaskableInstruction) begin
				interruptMaskLevel <= maskNow; // RULE_10
			end
			if (state == ST_IDLE && !accept) begin
				programCounter <= currentPc;
			end
			if (returnFromHandlerInstruction && popValid && state == ST_IDLE) begin
				programCounter <= poppedPc; // RULE_17
				systemModeFlag <= poppedSr[`SR_SYSTEM_MODE_FLAG_BIT]; // RULE_17
				interruptMaskLevel <= poppedSr[`SR_MASK_LSB+2:`SR_MASK_LSB]; // RULE_17
				registerBankPointer <= poppedSr[`SR_BANK_LSB+2:`SR_BANK_LSB];
				servicedLevel <= 3'h0;
			end
			if (accept) begin
				// Vector read clears the request in the controller
				vectorRead <= 1'b1; // RULE_12
				heldVector <= requestVector; // RULE_12 RULE_06
				heldLevel <= requestLevel;
				stateCount <= 5'd0;
			end else if (state != ST_IDLE) begin
				stateCount <= stateCount + 5'd1;
			end
			if (state == ST_PUSH) begin
				if (|dmaHit) begin
					dmaStart <= 1'b1; // RULE_22
					dmaChannel <= hitIndex;
				end else begin
					pushPc <= 1'b1; // RULE_13
					pushPcData <= programCounter;
					pushSrData <= srNow;
					interruptMaskLevel <= raisedMask; // RULE_14
					servicedLevel <= heldLevel; // RULE_19
					systemStackPointer <= systemStackPointer - 32'h00000006;
				end
			end
			if (state == ST_WAIT && stateCount == 5'd1) begin
				pushSr <= 1'b1; // RULE_13
			end
			if (state == ST_JUMP) begin
				systemModeFlag <= 1'b1; // RULE_15
				programCounter <= handlerAddr; // RULE_15
				branchTaken <= 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// file: test/intc_model.sv
// Interrupt controller model presenting one request at a time
`timescale 1ns/1ps
`default_nettype none
module intc_model (
	// Clock and reset
	input wire clk,
	input wire rst_b,
	// Request set by the bench
	input wire raise,
	input wire [2:0] raiseLevel,
	input wire [8:0] raiseVector,
	input wire raiseMaskable,
	// Vector read from the CPU
	input wire vectorRead,
	// Presented request
	output reg [2:0] requestLevel,
	output reg [8:0] requestVector,
	output reg requestMaskable
);
always @(posedge clk or negedge rst_b) begin
	if (!rst_b) begin
		requestLevel <= 3'h0;
		requestVector <= 9'h000;
		requestMaskable <= 1'h1;
	end else if (raise) begin
		requestLevel <= (raiseMaskable && raiseLevel == 3'h7) ? 3'h0 : raiseLevel;
		requestVector <= raiseVector;
		requestMaskable <= raiseMaskable;
	end else if (vectorRead) begin
		requestLevel <= 3'h0;
		requestVector <= ~requestVector;
	end
end
endmodule
`default_nettype wire

// file: test/entry_checker_asserts.sv
// Checker for the reset and interrupt entry unit
`timescale 1ns/1ps
`default_nettype none
module entry_checker (
	// Watched ports
	input wire clk,
	input wire rst_b,
	input wire [2:0] requestLevel,
	input wire [8:0] requestVector,
	input wire [31:0] dmaStartVectors,
	input wire vectorRead,
	input wire pushPc,
	input wire pushSr,
	input wire [23:0] programCounter,
	input wire [31:0] systemStackPointer,
	input wire [2:0] interruptMaskLevel,
	input wire systemModeFlag,
	input wire maximumModeFlag,
	input wire [2:0] registerBankPointer,
	input wire branchTaken,
	input wire entryBusy,
	input wire dmaStart,
	input wire [1:0] dmaChannel,
	input wire portsInput,
	input wire watchdogOutputPin,
	input wire watchdogEnable,
	input wire addressLatchStrobe
);
// ***
// Accepted level and vector
// ***
reg [2:0] lvl;
reg [8:0] vec;
always @(posedge clk) begin
	if (vectorRead) begin
		lvl <= requestLevel;
		vec <= requestVector;
	end
end
default clocking @(posedge clk); endclocking
default disable iff (!rst_b);
a_reset_state: assert property ($rose(rst_b) |-> systemStackPointer == 32'h100
	&& systemModeFlag && interruptMaskLevel == 3'h7) else $error("reset state wrong");
a_reset_flags: assert property ($rose(rst_b) |-> !maximumModeFlag
	&& registerBankPointer == 3'h0) else $error("reset flags wrong");
a_reset_pins: assert property ($rose(rst_b) |-> portsInput && !watchdogOutputPin
	&& watchdogEnable && !addressLatchStrobe) else $error("reset pins wrong");
a_vector_pulse: assert property (vectorRead |=> !vectorRead
	&& (pushPc || dmaStart)) else $error("vector read not followed");
a_push_order: assert property (pushPc |-> ##1 pushSr) else $error("status push late");
a_mask_raise: assert property (pushPc |-> ##[0:2]
	interruptMaskLevel == (lvl == 3'h7 ? 3'h7 : lvl + 3'h1)) else $error("mask not raised");
a_branch_target: assert property (branchTaken |-> ##[0:1]
	programCounter == 24'h008000 + vec && systemModeFlag) else $error("branch target wrong");
a_entry_bound: assert property ($rose(entryBusy) |-> ##[1:60]
	(branchTaken || dmaStart)) else $error("entry too long");
a_dma_code: assert property (dmaStart |->
	dmaStartVectors[8*dmaChannel +: 8] == {3'h0, vec[8:4]}) else $error("start code mismatch");
a_accept_gate: assert property (vectorRead |-> $past(requestLevel) == 3'h7
	|| $past(requestLevel) > $past(interruptMaskLevel)) else $error("accepted below mask");
endmodule
bind cpu_reset_and_interrupt_entry entry_checker chk (.clk, .rst_b, .requestLevel,
	.requestVector, .dmaStartVectors, .vectorRead, .pushPc, .pushSr, .programCounter,
	.systemStackPointer, .interruptMaskLevel, .systemModeFlag, .maximumModeFlag,
	.registerBankPointer, .branchTaken, .entryBusy, .dmaStart, .dmaChannel, .portsInput,
	.watchdogOutputPin, .watchdogEnable, .addressLatchStrobe);
`default_nettype wire

// file: test/tb_cpu_reset_and_interrupt_entry.sv
// Bench for the reset and interrupt entry unit
`timescale 1ns/1ps
`default_nettype none
module tb_cpu_reset_and_interrupt_entry;
reg clk = 1'h0, rst_b = 1'h1, raise = 1'h0, raiseMaskable = 1'h0, instructionBoundary = 1'h1;
reg maxMode = 1'h0, stackBus8 = 1'h0;
reg setMaskInstruction = 1'h0, blockMaskableInstruction = 1'h0;
reg returnFromHandlerInstruction = 1'h0, popValid = 1'h0, seen, chan;
reg [2:0] raiseLevel = 3'h0, setMaskOperand = 3'h0;
reg [8:0] raiseVector = 9'h000;
reg [23:0] poppedPc = 24'h000000, currentPc = 24'h00abcd;
reg [15:0] poppedSr = 16'h0000;
reg [31:0] dmaStartVectors = 32'h00080000;
wire [2:0] requestLevel, interruptMaskLevel, registerBankPointer;
wire [8:0] requestVector;
wire [23:0] pushPcData, programCounter;
wire [15:0] pushSrData;
wire [31:0] systemStackPointer;
wire [1:0] dmaChannel;
wire requestMaskable, vectorRead, pushPc, pushSr, systemModeFlag, maximumModeFlag, branchTaken;
wire entryBusy, dmaStart, portsInput, watchdogOutputPin, watchdogEnable, clockOutput;
wire addressLatchStrobe;
integer mismatches = 0, cmp_count = 0, lat = 0;
always #50 clk = ~clk;
intc_model ctl (.clk, .rst_b, .raise, .raiseLevel, .raiseVector, .raiseMaskable, .vectorRead,
	.requestLevel, .requestVector, .requestMaskable);
cpu_reset_and_interrupt_entry uut (.clk, .rst_b, .requestLevel, .requestVector,
	.requestMaskable, .dmaStartVectors, .instructionBoundary, .setMaskInstruction,
	.setMaskOperand, .blockMaskableInstruction, .returnFromHandlerInstruction, .poppedPc,
	.poppedSr, .popValid, .currentPc, .maxMode, .stackBus8,
	.stackPointerIn(32'h00000000), .stackPointerLoad(1'h0), .vectorRead, .pushPc, .pushSr,
	.pushPcData, .pushSrData, .programCounter, .systemStackPointer, .interruptMaskLevel,
	.systemModeFlag, .maximumModeFlag, .registerBankPointer, .branchTaken, .entryBusy,
	.dmaStart, .dmaChannel, .portsInput, .watchdogOutputPin, .watchdogEnable, .clockOutput,
	.addressLatchStrobe);
// ***
// Tasks
// ***
task cmp(input string nm, input [31:0] exp, input [31:0] got);
	begin
		cmp_count = cmp_count + 1;
		if (got !== exp) begin
			mismatches = mismatches + 1;
			$display("Error %0s expected %h seen %h", nm, exp, got);
		end
	end
endtask
task instr(input [2:0] op, input blk);
	begin
		@(posedge clk);
		setMaskInstruction <= !blk;
		blockMaskableInstruction <= blk;
		setMaskOperand <= op;
		@(posedge clk);
		setMaskInstruction <= 1'h0;
		blockMaskableInstruction <= 1'h0;
		@(negedge clk);
	end
endtask
// Present one request, watch 40 cycles for entry or a micro DMA start, then withdraw it
task present(input [2:0] lv, input [8:0] vc, input mk, input exp);
	integer i;
	begin
		seen = 1'h0;
		@(posedge clk);
		raise <= 1'h1;
		raiseLevel <= lv;
		raiseVector <= vc;
		raiseMaskable <= mk;
		@(posedge clk);
		raise <= 1'h0;
		for (i = 0; i < 40; i = i + 1) begin
			@(negedge clk);
			if (branchTaken === 1'h1 || dmaStart === 1'h1) begin
				// Cycles from the edge the model latches the request: acceptance takes one, then the entry states
				if (!seen)
					lat = i;
				seen = 1'h1;
				chan = dmaChannel == 2'h2;
			end
		end
		@(posedge clk);
		raise <= 1'h1;
		raiseLevel <= 3'h0;
		@(posedge clk);
		raise <= 1'h0;
		@(negedge clk);
		cmp("taken", exp, seen);
	end
endtask
task close_out;
	begin
		$display("Counts: %0d compared, %0d mismatched", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	end
endtask
// ***
// Tests
// ***
initial begin
	#200000;
	mismatches = mismatches + 1;
	close_out;
end
initial begin
	rst_b <= 1'h0;
	repeat (15) @(negedge clk);
	cmp("pc", 24'h008000, programCounter);
	cmp("sp", 32'h100, systemStackPointer);
	cmp("mask", 3'h7, interruptMaskLevel);
	cmp("bank", 3'h0, registerBankPointer);
	cmp("system_mode_flag", 1'h1, systemModeFlag);
	cmp("wdog", 1'h0, watchdogOutputPin);
	cmp("alat", 1'h0, addressLatchStrobe);
	cmp("ports", 1'h1, portsInput);
	cmp("wden", 1'h1, watchdogEnable);
	cmp("clko", 1'h1, clockOutput);
	@(posedge clk);
	rst_b <= 1'h1;
	$display("Test reset done");
	present(3'h3, 9'h040, 1'h1, 1'h0);
	instr(3'h2, 1'h0);
	present(3'h3, 9'h040, 1'h1, 1'h1);
	cmp("states", 16, lat);
	cmp("mask", 3'h4, interruptMaskLevel);
	cmp("pushpc", 24'h00abcd, pushPcData);
	cmp("pushsr", 16'ha000, pushSrData);
	present(3'h4, 9'h050, 1'h1, 1'h0);
	$display("Test entry done");
	@(posedge clk);
	returnFromHandlerInstruction <= 1'h1;
	popValid <= 1'h1;
	poppedPc <= 24'h00beef;
	poppedSr <= 16'ha200;
	@(posedge clk);
	returnFromHandlerInstruction <= 1'h0;
	popValid <= 1'h0;
	repeat (3) @(negedge clk);
	cmp("mask", 3'h2, interruptMaskLevel);
	cmp("bank", 3'h2, registerBankPointer);
	$display("Test return done");
	instr(3'h0, 1'h1);
	cmp("mask", 3'h7, interruptMaskLevel);
	present(3'h6, 9'h060, 1'h1, 1'h0);
	present(3'h7, 9'h070, 1'h0, 1'h1);
	cmp("mask", 3'h7, interruptMaskLevel);
	$display("Test nonmaskable done");
	instr(3'h0, 1'h0);
	present(3'h5, 9'h080, 1'h1, 1'h1);
	cmp("chan", 1'h1, chan);
	$display("Test dma done");
	// Higher request during entry must nest into one branch
	@(posedge clk);
	raise <= 1'h1;
	raiseLevel <= 3'h2;
	raiseVector <= 9'h0a0;
	raiseMaskable <= 1'h1;
	@(posedge clk);
	raise <= 1'h0;
	repeat (4) @(posedge clk);
	raise <= 1'h1;
	raiseLevel <= 3'h5;
	raiseVector <= 9'h0b0;
	@(posedge clk);
	raise <= 1'h0;
	lat = 0;
	repeat (30) begin
		@(negedge clk);
		if (branchTaken === 1'h1)
			lat = lat + 1;
	end
	cmp("branches", 1, lat);
	cmp("mask", 3'h6, interruptMaskLevel);
	$display("Test nest done");
	@(posedge clk);
	instructionBoundary <= 1'h0;
	present(3'h7, 9'h090, 1'h0, 1'h0);
	@(posedge clk);
	instructionBoundary <= 1'h1;
	$display("Test boundary done");
	instr(3'h0, 1'h0);
	@(posedge clk);
	maxMode <= 1'h1;
	stackBus8 <= 1'h1;
	present(3'h3, 9'h180, 1'h1, 1'h1);
	cmp("states", 24, lat);
	$display("Test timing done");
	close_out;
end
endmodule
`default_nettype wire
